// *** design/hash_pkg.sv ***
// Package: constants, types and helpers of the hash engine
package hash_pkg;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic {MODE_SHA1, MODE_SHA256} hash_mode_t;

	typedef struct packed {
		logic req;
		logic [31:0] addr;
	} fetch_req_t;

	// ****************************************
	// Sizes and counts
	// ****************************************
	localparam int BLOCK_BYTES = 64;
	localparam int MAX_FETCH_BYTES = 131072;
	localparam int BLKCNT_W = 12;
	localparam logic [BLKCNT_W-1:0] MAX_BLOCKS = BLKCNT_W'(MAX_FETCH_BYTES / BLOCK_BYTES);
	localparam logic [4:0] LAST_WORD = 5'h0F;
	localparam logic [6:0] ROUNDS_SHA1 = 7'h50;
	localparam logic [6:0] ROUNDS_SHA256 = 7'h40;
	localparam logic [6:0] SHA1_STAGE = 7'h14;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;

	// ****************************************
	// Initial values and round constants
	// ****************************************
	localparam logic [31:0] IV_SHA256 [8] = '{
		32'h6A09E667, 32'hBB67AE85, 32'h3C6EF372, 32'hA54FF53A,
		32'h510E527F, 32'h9B05688C, 32'h1F83D9AB, 32'h5BE0CD19};
	localparam logic [31:0] IV_SHA1 [8] = '{
		32'h67452301, 32'hEFCDAB89, 32'h98BADCFE, 32'h10325476,
		32'hC3D2E1F0, 32'h00000000, 32'h00000000, 32'h00000000};
	localparam logic [31:0] K_SHA1 [4] = '{
		32'h5A827999, 32'h6ED9EBA1, 32'h8F1BBCDC, 32'hCA62C1D6};
	localparam logic [31:0] K_SHA256 [64] = '{
		32'h428A2F98, 32'h71374491, 32'hB5C0FBCF, 32'hE9B5DBA5,
		32'h3956C25B, 32'h59F111F1, 32'h923F82A4, 32'hAB1C5ED5,
		32'hD807AA98, 32'h12835B01, 32'h243185BE, 32'h550C7DC3,
		32'h72BE5D74, 32'h80DEB1FE, 32'h9BDC06A7, 32'hC19BF174,
		32'hE49B69C1, 32'hEFBE4786, 32'h0FC19DC6, 32'h240CA1CC,
		32'h2DE92C6F, 32'h4A7484AA, 32'h5CB0A9DC, 32'h76F988DA,
		32'h983E5152, 32'hA831C66D, 32'hB00327C8, 32'hBF597FC7,
		32'hC6E00BF3, 32'hD5A79147, 32'h06CA6351, 32'h14292967,
		32'h27B70A85, 32'h2E1B2138, 32'h4D2C6DFC, 32'h53380D13,
		32'h650A7354, 32'h766A0ABB, 32'h81C2C92E, 32'h92722C85,
		32'hA2BFE8A1, 32'hA81A664B, 32'hC24B8B70, 32'hC76C51A3,
		32'hD192E819, 32'hD6990624, 32'hF40E3585, 32'h106AA070,
		32'h19A4C116, 32'h1E376C08, 32'h2748774C, 32'h34B0BCB5,
		32'h391C0CB3, 32'h4ED8AA4A, 32'h5B9CCA4F, 32'h682E6FF3,
		32'h748F82EE, 32'h78A5636F, 32'h84C87814, 32'h8CC70208,
		32'h90BEFFFA, 32'hA4506CEB, 32'hBEF9A3F7, 32'hC67178F2};

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] rotr(input logic [31:0] x, input int n);
		return (x >> n) | (x << (32 - n));
	endfunction : rotr

endpackage : hash_pkg

// *** design/hash_engine.sv ***
// Hash engine: SHA-1 / SHA2-256 core with word port and memory fetch master
// Operation
// - Computes SHA-1 or SHA2-256 digest, mode chosen by software at new hash.
// - Own master fetches consecutive blocks, at most 128 K bytes per run.
// - First hand-written word of a block clears digest ready.
// - Launching a mastered continuation clears digest ready.
`timescale 1ns/1ns
`default_nettype none
module hash_engine
	import hash_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic hash_new,
	input wire logic hash_mode,
	input wire logic word_wr,
	input wire logic [31:0] hash_input_word_port,
	input wire logic addr_wr,
	input wire logic [31:0] master_fetch_start_address,
	input wire logic ctrl_wr,
	input wire logic [BLKCNT_W-1:0] master_fetch_control,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output fetch_req_t fetch,
	output logic digest_ready,
	output logic busy,
	output logic [255:0] digest
);

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [1:0] {S_FILL, S_HASH, S_SUM} state_t;

	state_t state, next_state;
	hash_mode_t mode, next_mode;
	logic [31:0] h [8];
	logic [31:0] next_h [8];
	logic [31:0] v [8];
	logic [31:0] next_v [8];
	logic [31:0] w [16];
	logic [31:0] next_w [16];
	logic [6:0] round, next_round;
	logic [4:0] wcnt, next_wcnt;
	logic [BLKCNT_W-1:0] mst_left, next_mst_left;
	logic [31:0] start_addr, next_start_addr;
	fetch_req_t next_fetch;
	logic next_ready, next_busy;

	logic mastering, load_word, ctrl_take;
	logic [31:0] in_word, wnew, t1, t2, f1, k1;
	logic [1:0] stage;

	assign mastering = (mst_left != '0);
	assign ctrl_take = ctrl_wr && !mastering;
	assign digest = {h[0], h[1], h[2], h[3], h[4], h[5], h[6], h[7]};

	// ****************************************
	// Round arithmetic
	// ****************************************
	always_comb
	begin
		stage = 2'h3;
		if (round < SHA1_STAGE)
			stage = 2'h0;
		else if (round < 7'(SHA1_STAGE * 2))
			stage = 2'h1;
		else if (round < 7'(SHA1_STAGE * 3))
			stage = 2'h2;
		k1 = K_SHA1[stage];
		unique case (stage)
			2'h0: f1 = (v[1] & v[2]) | (~v[1] & v[3]);
			2'h2: f1 = (v[1] & v[2]) | (v[1] & v[3]) | (v[2] & v[3]);
			default: f1 = v[1] ^ v[2] ^ v[3];
		endcase
		if (mode == MODE_SHA256)
		begin
			t1 = v[7] + (rotr(v[4], 6) ^ rotr(v[4], 11) ^ rotr(v[4], 25))
				+ ((v[4] & v[5]) ^ (~v[4] & v[6])) + K_SHA256[round[5:0]] + w[0];
			t2 = (rotr(v[0], 2) ^ rotr(v[0], 13) ^ rotr(v[0], 22))
				+ ((v[0] & v[1]) ^ (v[0] & v[2]) ^ (v[1] & v[2]));
			wnew = (rotr(w[14], 17) ^ rotr(w[14], 19) ^ (w[14] >> 10)) + w[9]
				+ (rotr(w[1], 7) ^ rotr(w[1], 18) ^ (w[1] >> 3)) + w[0];
		end
		else
		begin
			t1 = rotr(v[0], 27) + f1 + v[4] + k1 + w[0];
			t2 = '0;
			wnew = rotr(w[13] ^ w[8] ^ w[2] ^ w[0], 31);
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		next_state = state;
		next_mode = mode;
		next_h = h;
		next_v = v;
		next_w = w;
		next_round = round;
		next_wcnt = wcnt;
		next_mst_left = mst_left;
		next_start_addr = start_addr;
		next_fetch = fetch;
		next_ready = digest_ready;
		load_word = 1'b0;
		in_word = hash_input_word_port;
		if (addr_wr)
			next_start_addr = master_fetch_start_address;
		if (ctrl_take && master_fetch_control != '0)
		begin
			next_mst_left = (master_fetch_control > MAX_BLOCKS) ? MAX_BLOCKS
				: master_fetch_control;
			next_fetch.addr = start_addr;
			next_ready = 1'b0;
		end
		unique case (state)
			S_FILL:
			begin
				if (hash_new && !mastering)
				begin
					next_mode = hash_mode_t'(hash_mode);
					if (hash_mode_t'(hash_mode) == MODE_SHA256)
						next_h = IV_SHA256;
					else
						next_h = IV_SHA1;
					next_wcnt = '0;
					next_ready = 1'b0;
				end
				else if (mastering)
				begin
					load_word = fetch.req && mem_ack;
					in_word = mem_rdata;
					if (load_word)
						next_fetch.addr = fetch.addr + WORD_STEP;
				end
				else
				begin
					load_word = word_wr;
					if (word_wr)
						next_ready = 1'b0;
				end
				if (load_word)
				begin
					for (int i = 0; i < 15; i++)
						next_w[i] = w[i + 1];
					next_w[15] = in_word;
					next_wcnt = wcnt + 5'h01;
					if (wcnt == LAST_WORD)
					begin
						next_state = S_HASH;
						next_round = '0;
						next_v = h;
						if (mastering)
							next_mst_left = mst_left - 1'b1;
					end
				end
			end
			S_HASH:
			begin
				for (int i = 0; i < 15; i++)
					next_w[i] = w[i + 1];
				next_w[15] = wnew;
				if (mode == MODE_SHA256)
					next_v = '{t1 + t2, v[0], v[1], v[2], v[3] + t1, v[4], v[5], v[6]};
				else
					next_v = '{t1, v[0], rotr(v[1], 2), v[2], v[3], v[5], v[6], v[7]};
				next_round = round + 7'h01;
				if (round == ((mode == MODE_SHA256) ? ROUNDS_SHA256 : ROUNDS_SHA1) - 7'h01)
					next_state = S_SUM;
			end
			S_SUM:
			begin
				for (int i = 0; i < 8; i++)
					next_h[i] = (mode == MODE_SHA1 && i > 4) ? h[i] : h[i] + v[i];
				next_wcnt = '0;
				next_state = S_FILL;
				if (!mastering && !ctrl_take)
					next_ready = 1'b1;
			end
		endcase
		next_fetch.req = (next_state == S_FILL) && (next_mst_left != '0);
		next_busy = (next_state != S_FILL) || (next_mst_left != '0);
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state <= S_FILL;
			mode <= MODE_SHA256;
			h <= '{default: 32'h0000_0000};
			v <= '{default: 32'h0000_0000};
			w <= '{default: 32'h0000_0000};
			round <= '0;
			wcnt <= '0;
			mst_left <= '0;
			start_addr <= '0;
			fetch <= '0;
			digest_ready <= 1'b0;
			busy <= 1'b0;
		end
		else
		begin
			state <= next_state;
			mode <= next_mode;
			h <= next_h;
			v <= next_v;
			w <= next_w;
			round <= next_round;
			wcnt <= next_wcnt;
			mst_left <= next_mst_left;
			start_addr <= next_start_addr;
			fetch <= next_fetch;
			digest_ready <= next_ready;
			busy <= next_busy;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_last_round;
		state == S_HASH && round == ((mode == MODE_SHA256) ? ROUNDS_SHA256 : ROUNDS_SHA1) - 7'h01;
	endsequence

	sequence s_sum_then_fill;
		state == S_SUM ##1 state == S_FILL;
	endsequence

	a_round_count: assert property (@(posedge mclk) disable iff (rst)
		s_last_round |=> s_sum_then_fill)
		else $error("hash rounds did not end in sum");
	a_hash_starts: assert property (@(posedge mclk) disable iff (rst)
		$rose(state == S_HASH) |-> round == 7'h00 && wcnt == 5'h10)
		else $error("hash began without a full block");
	a_fetch_stride: assert property (@(posedge mclk) disable iff (rst)
		fetch.req && mem_ack && state == S_FILL |=> fetch.addr == $past(fetch.addr) + WORD_STEP)
		else $error("fetch address did not advance one word");
	a_fetch_limit: assert property (@(posedge mclk) disable iff (rst)
		mst_left <= MAX_BLOCKS)
		else $error("fetch run exceeds block limit");
	a_word_clears: assert property (@(posedge mclk) disable iff (rst)
		state == S_FILL && !mastering && word_wr && !ctrl_take |=> !digest_ready)
		else $error("hand-fed word left digest ready set");
	a_ctrl_clears: assert property (@(posedge mclk) disable iff (rst)
		ctrl_take && master_fetch_control != '0 |=> !digest_ready && busy)
		else $error("continuation left digest ready set");
	a_ready_sets: assert property (@(posedge mclk) disable iff (rst)
		state == S_SUM && !mastering && !ctrl_take |=> digest_ready ##1 (digest_ready || $past(
		ctrl_wr || hash_new || word_wr)))
		else $error("digest ready not set after last block");

endmodule : hash_engine
`default_nettype wire

// *** sim/hash_mem_model.sv ***
// Memory model that answers the hash engine's fetch master
`timescale 1ns/1ns
`default_nettype none
module hash_mem_model
	import hash_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire fetch_req_t fetch,
	input wire logic [3:0] lat,
	output var logic mem_ack,
	output var logic [31:0] mem_rdata
);
	logic [31:0] mem [32];
	logic [3:0] cnt;

	// ****************************************
	// Contents: two padded blocks from 0x100
	// ****************************************
	initial
	begin
		foreach (mem[i])
			mem[i] = (i % 16 == 0) ? 32'h61626380 : ((i % 16 == 15) ? 32'h00000018 : 32'h0);
	end

	// ****************************************
	// Answer after lat idle cycles
	// ****************************************
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cnt <= 4'h0;
			mem_ack <= 1'b0;
			mem_rdata <= 32'hA5A5A5A5;
		end
		else if (fetch.req && !mem_ack && cnt >= lat)
		begin
			mem_ack <= 1'b1;
			mem_rdata <= mem[fetch.addr[6:2]];
			cnt <= 4'h0;
		end
		else
		begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			cnt <= fetch.req ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule : hash_mem_model
`default_nettype wire

// *** sim/hash_engine_tb.sv ***
// Testbench of the hash engine
`timescale 1ns/1ns
`default_nettype none
module hash_engine_tb
	import hash_pkg::*;
;
	logic mclk, rst, hash_new, hash_mode, word_wr, addr_wr, ctrl_wr, mem_ack, digest_ready, busy;
	logic [31:0] word_in, start_addr, mem_rdata;
	logic [BLKCNT_W-1:0] count;
	logic [3:0] lat;
	logic [255:0] digest;
	fetch_req_t fetch;
	int n_fail, checked;
	localparam logic [159:0] SHA1_ABC = 160'hA9993E364706816ABA3E25717850C26C9CD0D89D;
	localparam logic [255:0] SHA256_ABC =
		256'hBA7816BF8F01CFEA414140DE5DAE2223B00361A396177A9CB410FF61F20015AD;

	hash_engine dut (.mclk(mclk), .rst(rst), .hash_new(hash_new), .hash_mode(hash_mode),
		.word_wr(word_wr), .hash_input_word_port(word_in), .addr_wr(addr_wr),
		.master_fetch_start_address(start_addr), .ctrl_wr(ctrl_wr),
		.master_fetch_control(count), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.fetch(fetch), .digest_ready(digest_ready), .busy(busy), .digest(digest));
	hash_mem_model mem_i (.mclk(mclk), .rst(rst), .fetch(fetch), .lat(lat),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [255:0] seen, input logic [255:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// sel: 0 new hash, 1 word, 2 address, 3 control
	task automatic strobe(input int sel, input logic [31:0] v);
		@(negedge mclk);
		{word_in, start_addr, count, hash_mode} = {v, v, v[BLKCNT_W-1:0], v[0]};
		{hash_new, word_wr, addr_wr, ctrl_wr} = {sel == 0, sel == 1, sel == 2, sel == 3};
		@(negedge mclk);
		{hash_new, word_wr, addr_wr, ctrl_wr} = 4'h0;
	endtask : strobe

	task automatic feed(input int first);
		for (int i = first; i < 16; i++)
			strobe(1, (i == 0) ? 32'h61626380 : ((i == 15) ? 32'h00000018 : 32'h0));
	endtask : feed

	task automatic wait_ready();
		int n;
		n = 0;
		while (digest_ready !== 1'b1 && n < 1000)
		begin
			@(negedge mclk);
			n++;
		end
		check(digest_ready, 1'b1);
	endtask : wait_ready

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	// ****************************************
	// Clock, watchdog, tests
	// ****************************************
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	initial
	begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		end_sim();
	end

	initial
	begin
		{hash_new, hash_mode, word_wr, addr_wr, ctrl_wr} = 5'h0;
		{word_in, start_addr, count, lat, n_fail, checked} = '0;
		rst = 1'b1;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		strobe(0, 32'h0);
		feed(0);
		wait_ready();
		check(digest, {SHA1_ABC, 96'h0});
		repeat (10) @(negedge mclk);
		check(digest_ready, 1'b1);
		strobe(1, 32'h61626380);
		check(digest_ready, 1'b0);
		feed(1);
		strobe(2, 32'h100);
		strobe(3, 32'h1);
		check(busy, 1'b1);
		repeat (80) @(negedge mclk);
		check(digest_ready, 1'b0);
		wait_ready();
		check(fetch.addr, 32'h140);
		strobe(0, 32'h1);
		strobe(2, 32'h100);
		lat = 4'h3;
		strobe(3, 32'h1);
		@(negedge mclk);
		check(fetch.req, 1'b1);
		check(fetch.addr, 32'h100);
		wait_ready();
		check(digest, SHA256_ABC);
		lat = 4'h0;
		strobe(3, 32'h2);
		check(digest_ready, 1'b0);
		check(busy, 1'b1);
		strobe(3, 32'hFFF);
		wait_ready();
		check(busy, 1'b0);
		check(fetch.addr, 32'h180);
		strobe(3, 32'h0);
		repeat (3) @(negedge mclk);
		check(busy, 1'b0);
		check(digest_ready, 1'b1);
		end_sim();
	end
endmodule : hash_engine_tb
`default_nettype wire
